// ### pkg/pbc_pkg.sv
// Constants and carrier types for the power budgeting capability register bank
// What this block does
// R1 - Header bits 15:0 hold a 16-bit capability identifier; 0x4 means power budgeting.
// R2 - Header bits 19:16 hold a 4-bit capability version; 0x1 means version 1.
// R3 - An 8-bit data-value selector chooses which stored power data value is shown.
// R4 - A selector value above 7 makes the data window read all zeros.
// R5 - The 32-bit data window is read-only and shows the selected data value.
// R6 - Bit 0 of the system allocation register flags budget counted in system budget.
// R7 - The EEPROM loader should initialise identifier, version and flag; all reset to zero. The code has no loader; they are written over the bus while unlocked.
// R8 - Eight 32-bit data values from 0x300 accept writes only while unlocked.
// R9 - A window read reflects the latest selector write without extra delay.
package pbc_pkg;

  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned DV_COUNT = 8;
  localparam int unsigned DV_IDX_W = 3;
  localparam int unsigned SEL_W    = 8;

  localparam logic [ADDR_W-1:0] OFS_HEADER  = 12'h280;
  localparam logic [ADDR_W-1:0] OFS_SELECT  = 12'h284;
  localparam logic [ADDR_W-1:0] OFS_WINDOW  = 12'h288;
  localparam logic [ADDR_W-1:0] OFS_SYSALLOC = 12'h28c;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK  = 12'h2a0;
  localparam logic [ADDR_W-1:0] OFS_DV_BASE = 12'h300;

  localparam int unsigned IDENT_LSB   = 0;
  localparam int unsigned IDENT_MSB   = 15;
  localparam int unsigned VERSION_LSB = 16;
  localparam int unsigned VERSION_MSB = 19;
  localparam int unsigned ALLOC_BIT   = 0;
  localparam int unsigned UNLOCK_BIT  = 0;

  localparam logic [DATA_W-1:0] RST_HEADER = 32'h0000_0000;
  localparam logic [SEL_W-1:0]  RST_SELECT = 8'h00;
  localparam logic [DATA_W-1:0] RST_DV     = 32'h0000_0000;
  localparam logic              RST_ALLOC  = 1'b0;
  localparam logic              RST_UNLOCK = 1'b0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef logic [DV_COUNT-1:0][DATA_W-1:0] pbc_dv_t;

  typedef struct packed {
    logic [DATA_W-1:0] header;
    logic [SEL_W-1:0]  select;
    logic              sys_alloc;
    logic              unlock;
    pbc_dv_t           dv;
    logic              wr_pend;
    logic              rd_pend;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] hrdata;
    logic              hreadyout;
    logic              hresp;
  } pbc_state_s;

endpackage

// ### core/pbc_regs.sv
// AHB-Lite register bank of the power budgeting capability
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module pbc_regs (
  input  wire logic                         REF_CLK,
  input  wire logic                         SYS_RST,
  input  wire logic                         HSEL,
  input  wire logic [pbc_pkg::ADDR_W-1:0]   HADDR,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [pbc_pkg::DATA_W-1:0]   HWDATA,
  input  wire logic                         HREADY,
  output logic      [pbc_pkg::DATA_W-1:0]   HRDATA,
  output logic                              HREADYOUT,
  output logic                              HRESP,
  output logic                              SYS_ALLOCATED
);
  import pbc_pkg::*;

  pbc_state_s st_ff;
  pbc_state_s nxt_st;

  // Data window contents for a given selector; out-of-range reads zero
  function automatic logic [DATA_W-1:0] window_of(input logic [SEL_W-1:0] sel, input pbc_dv_t dv);
    if (sel < SEL_W'(DV_COUNT)) begin // [R4]
      window_of = dv[sel[DV_IDX_W-1:0]]; // [R3] [R5]
    end else begin
      window_of = '0; // [R4]
    end
  endfunction

  function automatic logic is_dv(input logic [ADDR_W-1:0] a);
    is_dv = (a[ADDR_W-1:DV_IDX_W+2] == OFS_DV_BASE[ADDR_W-1:DV_IDX_W+2]);
  endfunction

  logic        accept;
  logic [31:0] rd_value;

  assign accept = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);

  always_comb begin
    case (st_ff.addr)
      OFS_HEADER:   rd_value = st_ff.header; // [R1] [R2]
      OFS_SELECT:   rd_value = {{(DATA_W-SEL_W){1'b0}}, st_ff.select};
      OFS_WINDOW:   rd_value = window_of(st_ff.select, st_ff.dv); // [R5] [R9]
      OFS_SYSALLOC: rd_value = {{(DATA_W-1){1'b0}}, st_ff.sys_alloc}; // [R6]
      OFS_UNLOCK:   rd_value = {{(DATA_W-1){1'b0}}, st_ff.unlock};
      default: begin
        if (is_dv(st_ff.addr)) begin
          rd_value = st_ff.dv[st_ff.addr[DV_IDX_W+1:2]];
        end else begin
          rd_value = '0;
        end
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // Write data phase completes with no wait; commit the pending write here
    if (st_ff.wr_pend) begin
      nxt_st.wr_pend = 1'b0;
      case (st_ff.addr)
        OFS_HEADER: begin
          // Lockable fields share the unlock with the data values
          if (st_ff.unlock) begin
            nxt_st.header = HWDATA; // [R1] [R2]
          end
        end
        OFS_SELECT:   nxt_st.select = HWDATA[SEL_W-1:0]; // [R3]
        OFS_SYSALLOC: begin
          if (st_ff.unlock) begin
            nxt_st.sys_alloc = HWDATA[ALLOC_BIT]; // [R6]
          end
        end
        OFS_UNLOCK:   nxt_st.unlock = HWDATA[UNLOCK_BIT];
        default: begin
          if (is_dv(st_ff.addr) && st_ff.unlock) begin
            nxt_st.dv[st_ff.addr[DV_IDX_W+1:2]] = HWDATA; // [R8]
          end
        end
      endcase
    end
    // Reads take one wait state so registered data sees any write just committed
    if (st_ff.rd_pend) begin
      nxt_st.rd_pend   = 1'b0;
      nxt_st.hrdata    = rd_value; // [R9]
      nxt_st.hreadyout = 1'b1;
    end
    if (accept) begin
      nxt_st.addr = {HADDR[ADDR_W-1:2], 2'b00};
      if (HWRITE) begin
        nxt_st.wr_pend = 1'b1;
      end else begin
        nxt_st.rd_pend   = 1'b1;
        nxt_st.hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff.header    <= RST_HEADER; // [R7]
      st_ff.select    <= RST_SELECT;
      st_ff.sys_alloc <= RST_ALLOC;
      st_ff.unlock    <= RST_UNLOCK;
      st_ff.dv        <= {DV_COUNT{RST_DV}};
      st_ff.wr_pend   <= 1'b0;
      st_ff.rd_pend   <= 1'b0;
      st_ff.addr      <= '0;
      st_ff.hrdata    <= '0;
      st_ff.hreadyout <= 1'b1;
      // Every access is answered OKAY, so this flop never leaves its reset value
      st_ff.hresp     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign HRDATA        = st_ff.hrdata;
  assign HREADYOUT     = st_ff.hreadyout;
  assign HRESP         = st_ff.hresp;
  assign SYS_ALLOCATED = st_ff.sys_alloc;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_read_of(logic [ADDR_W-1:0] a);
    accept && !HWRITE && ({HADDR[ADDR_W-1:2], 2'b00} == a);
  endsequence

  sequence s_write_of(logic [ADDR_W-1:0] a);
    accept && HWRITE && ({HADDR[ADDR_W-1:2], 2'b00} == a);
  endsequence

  sequence s_one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  chk_read_one_wait: assert property (s_read_of(HADDR) |=> s_one_wait) // [R9]
    else $error("Read did not complete after exactly one wait state");

  chk_window_zero_high: assert property ( // [R4]
    s_read_of(OFS_WINDOW) ##1 (st_ff.select > 8'h07) |=> HRDATA == 32'h0)
    else $error("Window read with selector above 7 did not return zero");

  chk_window_selected: assert property ( // [R5]
    s_read_of(OFS_WINDOW) ##1 (st_ff.select <= 8'h07) |=> HRDATA == $past(st_ff.dv[st_ff.select[2:0]]))
    else $error("Window read did not return the selected data value");

  chk_select_latest: assert property ( // [R3]
    s_write_of(OFS_SELECT) ##1 !accept ##1 s_read_of(OFS_WINDOW) |=> ##1
      HRDATA == (($past(HWDATA[SEL_W-1:0], 3) > 8'h07) ? 32'h0 : st_ff.dv[$past(HWDATA[DV_IDX_W-1:0], 3)]))
    else $error("Window read after selector write used a stale selector");

  chk_dv_locked: assert property ( // [R8]
    st_ff.wr_pend && !st_ff.unlock |=> $stable(st_ff.dv))
    else $error("Data value changed while writes were locked");

  chk_dv_unlocked_write: assert property ( // [R8]
    st_ff.wr_pend && st_ff.unlock && is_dv(st_ff.addr)
      |=> st_ff.dv[$past(st_ff.addr[4:2])] == $past(HWDATA))
    else $error("Unlocked data value write was not stored");

  chk_capability_identifier_readback: assert property ( // [R1]
    s_read_of(OFS_HEADER) |=> ##1 HRDATA[IDENT_MSB:IDENT_LSB] == st_ff.header[IDENT_MSB:IDENT_LSB])
    else $error("Capability identifier readback mismatch");

  chk_version_write: assert property ( // [R2]
    s_write_of(OFS_HEADER) ##1 st_ff.unlock |=> st_ff.header[VERSION_MSB:VERSION_LSB] == $past(HWDATA[19:16]))
    else $error("Capability version write was not stored");

  chk_version_readback: assert property ( // [R2]
    s_read_of(OFS_HEADER) |=> ##1 HRDATA[VERSION_MSB:VERSION_LSB] == st_ff.header[VERSION_MSB:VERSION_LSB])
    else $error("Capability version readback mismatch");

  chk_header_locked: assert property ( // [R1] [R2] [R6]
    st_ff.wr_pend && !st_ff.unlock |=> $stable(st_ff.header) && $stable(st_ff.sys_alloc))
    else $error("Lockable field changed while writes were locked");

  chk_window_read_only: assert property ( // [R5]
    st_ff.wr_pend && (st_ff.addr == OFS_WINDOW) |=> $stable(st_ff.dv) && $stable(st_ff.select))
    else $error("Write to the data window changed stored state");

  chk_select_stored: assert property ( // [R3]
    st_ff.wr_pend && (st_ff.addr == OFS_SELECT) |=> st_ff.select == $past(HWDATA[SEL_W-1:0]))
    else $error("Selector write was not stored");

  chk_select_upper_zero: assert property ( // [R3]
    s_read_of(OFS_SELECT) |=> ##1 HRDATA[DATA_W-1:SEL_W] == '0)
    else $error("Selector readback has nonzero upper bits");

  chk_sys_alloc_write: assert property ( // [R6]
    st_ff.wr_pend && st_ff.unlock && (st_ff.addr == OFS_SYSALLOC) |=> SYS_ALLOCATED == $past(HWDATA[ALLOC_BIT]))
    else $error("Unlocked system allocated write did not reach the output");

  chk_unlock_write: assert property ( // [R8]
    st_ff.wr_pend && (st_ff.addr == OFS_UNLOCK) |=> st_ff.unlock == $past(HWDATA[UNLOCK_BIT]))
    else $error("Unlock bit write was not stored");

  chk_rdata_hold: assert property (!st_ff.rd_pend |=> $stable(HRDATA)) // [R9]
    else $error("Read data changed without a completed read");

  chk_wait_single: assert property (!HREADYOUT |=> HREADYOUT) // [R9]
    else $error("Ready stayed low for more than one cycle");

  chk_write_no_wait: assert property (accept && HWRITE |=> HREADYOUT)
    else $error("Write data phase was stretched");

  chk_sys_alloc_read: assert property ( // [R6]
    s_read_of(OFS_SYSALLOC) |=> ##1 HRDATA == {31'h0, st_ff.sys_alloc})
    else $error("System allocated flag readback mismatch");

  chk_sys_alloc_pin: assert property (SYS_ALLOCATED == st_ff.sys_alloc) // [R6]
    else $error("System allocated output disagrees with register");

  chk_reset_fields: assert property ( // [R7]
    $fell(SYS_RST) |-> st_ff.header == 32'h0 && !st_ff.sys_alloc)
    else $error("Lockable fields not zero after reset");

  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("Slave gave a response other than OKAY");

endmodule // pbc_regs
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the power budgeting register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pbc_pkg::*;
  logic              REF_CLK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic              HSEL    = 1'b0;
  logic [ADDR_W-1:0] HADDR   = '0;
  logic [1:0]        HTRANS  = 2'h0;
  logic              HWRITE  = 1'b0;
  logic [DATA_W-1:0] HWDATA  = '0;
  wire  [DATA_W-1:0] HRDATA;
  wire               HREADYOUT;
  wire               HRESP;
  wire               SYS_ALLOCATED;
  int                num_errors = 0;
  int                cmp_count  = 0;
  int                cyc        = 0;
  logic [DATA_W-1:0] rd;

  always #2 REF_CLK = ~REF_CLK;

  // Single slave, so its ready is the bus ready
  pbc_regs i_pbc_regs (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SYS_ALLOCATED(SYS_ALLOCATED));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    HSEL   <= 1'b1;
    HADDR  <= a;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    chk("hresp", 32'h0, {31'h0, HRESP});
    chk("data_edges", w ? 32'h1 : 32'h2, 32'(n));
  endtask

  task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task automatic t_reset();
    rchk("header", OFS_HEADER, 32'h0);
    rchk("select", OFS_SELECT, 32'h0);
    rchk("window", OFS_WINDOW, 32'h0);
    rchk("sysalloc", OFS_SYSALLOC, 32'h0);
    chk("sys_pin", 32'h0, {31'h0, SYS_ALLOCATED});
    rchk("unmapped", 12'h290, 32'h0);
  endtask

  // Locked writes are dropped; unlocked ones land
  task automatic t_header();
    xfer(1'b1, OFS_HEADER, 32'h0001_0004);
    xfer(1'b1, OFS_SYSALLOC, 32'h1);
    xfer(1'b1, OFS_DV_BASE, 32'h1234_5678);
    rchk("hdr_locked", OFS_HEADER, 32'h0);
    rchk("sa_locked", OFS_SYSALLOC, 32'h0);
    rchk("dv_locked", OFS_WINDOW, 32'h0);
    xfer(1'b1, OFS_UNLOCK, 32'h1);
    xfer(1'b1, OFS_HEADER, 32'h0001_0004);
    rchk("hdr_id_ver", OFS_HEADER, 32'h0001_0004);
    xfer(1'b1, OFS_SYSALLOC, 32'hffff_ffff);
    rchk("sa_set", OFS_SYSALLOC, 32'h1);
    chk("sys_pin", 32'h1, {31'h0, SYS_ALLOCATED});
  endtask

  // Fill all eight values, then read each through the window right after its select
  task automatic t_window();
    for (int i = 0; i < DV_COUNT; i++) begin
      xfer(1'b1, OFS_DV_BASE + 12'(4 * i), 32'ha5a5_0000 | 32'(i * 17 + 1));
    end
    for (int i = DV_COUNT - 1; i >= 0; i--) begin
      xfer(1'b1, OFS_SELECT, 32'(i));
      rchk("window_sel", OFS_WINDOW, 32'ha5a5_0000 | 32'(i * 17 + 1));
    end
    xfer(1'b1, OFS_WINDOW, 32'hdead_beef);
    rchk("window_ro", OFS_WINDOW, 32'ha5a5_0001);
  endtask

  task automatic t_range();
    xfer(1'b1, OFS_SELECT, 32'hffff_ff08);
    rchk("select_w", OFS_SELECT, 32'h8);
    rchk("window_8", OFS_WINDOW, 32'h0);
    xfer(1'b1, OFS_SELECT, 32'hff);
    rchk("window_ff", OFS_WINDOW, 32'h0);
    xfer(1'b1, OFS_UNLOCK, 32'h0);
    xfer(1'b1, OFS_DV_BASE + 12'h1c, 32'h0);
    xfer(1'b1, OFS_SELECT, 32'h7);
    rchk("dv7_locked", OFS_WINDOW, 32'ha5a5_0078);
  endtask

  // Mid-run reset must clear the lockable fields and the flag output
  task automatic t_rerst();
    SYS_RST <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    rchk("hdr_rst", OFS_HEADER, 32'h0);
    rchk("sa_rst", OFS_SYSALLOC, 32'h0);
    rchk("select_rst", OFS_SELECT, 32'h0);
    chk("sys_pin_rst", 32'h0, {31'h0, SYS_ALLOCATED});
  endtask

  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_header();
    t_window();
    t_range();
    t_rerst();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
